// ---- src/eic_top.sv ----
// Purpose: six-pin external interrupt conditioner with APB registers
// Assumes: clk is the gear clock; lowFreqClock is a synchronous level
// Notes:   requests leave as one-cycle pulses, or as a level for
//          the high-level trigger of source four
`timescale 1ns/1ps
module eic_top (
	input  wire logic                  clk,
	input  wire logic                  reset,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [15:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// pins and system status
	input  wire logic [5:0]            extIrqLine,
	input  wire logic                  lowFreqClock,
	input  wire eic_pkg::eic_mode_t    opMode,
	// cpu interrupt logic
	input  wire logic                  masterIntEnableFlag,
	input  wire logic [5:0]            sourceEnableFlag,
	output logic      [5:0]            irqRequest,
	output logic      [5:0]            irqAccepted,
	output logic                       extIntClockGate
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------

	// clock gate bit for the whole block
	logic                  gate_q;
	// writable fields of sources one to four
	eic_pkg::eic_ctrl_t    ctrl_q [1:4];
	// read data and error, loaded in setup phase
	logic [31:0]           rdata_q;
	logic                  slverr_q;
	// shared fast divider
	logic [3:0]            fastCnt_q;
	// previous slow clock level and slow divider
	logic                  slowPrev_q;
	logic [1:0]            slowCnt_q;
	// slow sampling instant
	logic                  slowTick;
	// mode decode
	logic                  modeFast;
	logic                  modeSlow;
	logic                  modeRun;
	// per-source sampling controls
	logic [5:0]            sampleTick;
	logic [5:0]            needThree;
	// filtered levels and captured levels
	logic [5:0]            filtLevel;
	logic [5:0]            passLevel;
	// trigger select per source
	logic [1:0]            trigSel [0:5];
	// apb strobes
	logic                  wrStrobe;
	logic                  setupPhase;
	// address hits
	logic                  hitGate;
	logic [4:1]            hitCtrl;
	logic                  hitAny;
	// read value in setup phase
	logic [31:0]           rdata_d;

	// ----------------------------------------
	// operating mode decode
	// ----------------------------------------

	// one-hot mode into two flags
	always_comb begin
		modeFast = 1'b0;
		modeSlow = 1'b0;
		case (opMode)
			eic_pkg::MODE_FAST: begin
				// run and idle on the gear clock
				modeFast = 1'b1;
			end
			eic_pkg::MODE_SLOW: begin
				// run and sleep on the slow clock
				modeSlow = 1'b1;
			end
			eic_pkg::MODE_DEEP: begin
				// sampling stopped
				modeFast = 1'b0;
			end
			default: begin
				// illegal code acts as deep
				modeFast = 1'b0;
			end
		endcase
	end

	// sampling and requests only in run modes
	assign modeRun = modeFast || modeSlow;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------

	// access phase write takes effect at once
	assign wrStrobe   = psel && penable && pwrite;
	// setup phase loads the read data
	assign setupPhase = psel && !penable;

	// address compare per register
	always_comb begin
		hitGate    = paddr == eic_pkg::GATE_ADDR;
		hitCtrl[1] = paddr == eic_pkg::CTRL1_ADDR;
		hitCtrl[2] = paddr == eic_pkg::CTRL2_ADDR;
		hitCtrl[3] = paddr == eic_pkg::CTRL3_ADDR;
		hitCtrl[4] = paddr == eic_pkg::CTRL4_ADDR;
		hitAny     = hitGate || (|hitCtrl);
	end

	// ----------------------------------------
	// clock gate register
	// ----------------------------------------

	// software sets it before any control write
	always_ff @(posedge clk) begin
		if (reset) begin
			gate_q <= eic_pkg::GATE_RESET;
		end else if (wrStrobe && hitGate) begin
			gate_q <= pwdata[eic_pkg::GATE_BIT];
		end
	end

	assign extIntClockGate = gate_q;

	// ----------------------------------------
	// control registers, sources one to four
	// ----------------------------------------

	// writes need the clock gate open
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 1; i <= 4; i++) begin
				ctrl_q[i] <= eic_pkg::CTRL_RESET;
			end
		end else if (wrStrobe && gate_q) begin
			for (int i = 1; i <= 4; i++) begin
				// only trigger and interval are writable
				if (hitCtrl[i]) begin
					ctrl_q[i].trig <= pwdata[eic_pkg::TRIG_LSB +: 2];
					ctrl_q[i].interval <=
						pwdata[eic_pkg::INTERVAL_LSB +: 2];
				end
			end
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------

	// bits above the fields read as zero
	always_comb begin
		rdata_d = 32'h0;
		if (hitGate) begin
			rdata_d[eic_pkg::GATE_BIT] = gate_q;
		end
		for (int i = 1; i <= 4; i++) begin
			if (hitCtrl[i]) begin
				// bits seven to five stay zero
				rdata_d[eic_pkg::LEVEL_BIT] = passLevel[i];
				rdata_d[eic_pkg::TRIG_LSB +: 2] = ctrl_q[i].trig;
				rdata_d[eic_pkg::INTERVAL_LSB +: 2] =
					ctrl_q[i].interval;
			end
		end
	end

	// read data and error captured in setup phase
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_q  <= 32'h0;
			slverr_q <= 1'h0;
		end else if (setupPhase) begin
			rdata_q  <= pwrite ? 32'h0 : rdata_d;
			slverr_q <= !hitAny;
		end
	end

	// zero wait states
	assign pready  = 1'b1;
	assign prdata  = rdata_q;
	assign pslverr = slverr_q;

	// ----------------------------------------
	// fast sampling divider
	// ----------------------------------------

	// free-running count of gear clock periods
	always_ff @(posedge clk) begin
		if (reset || !gate_q) begin
			fastCnt_q <= 4'h0;
		end else begin
			fastCnt_q <= fastCnt_q + 4'h1;
		end
	end

	// ----------------------------------------
	// slow sampling divider
	// ----------------------------------------

	// count rising edges of the slow clock by four
	always_ff @(posedge clk) begin
		if (reset || !gate_q) begin
			slowPrev_q <= 1'h0;
			slowCnt_q  <= 2'h0;
		end else begin
			slowPrev_q <= lowFreqClock;
			if (lowFreqClock && !slowPrev_q) begin
				slowCnt_q <= slowCnt_q + 2'h1;
			end
		end
	end

	// one tick every fourth slow rising edge
	assign slowTick = lowFreqClock && !slowPrev_q &&
		(slowCnt_q == eic_pkg::SLOW_DIV_LAST);

	// ----------------------------------------
	// per-source sampling control
	// ----------------------------------------

	// select tick and agreement depth per source
	always_comb begin
		for (int s = 0; s < 6; s++) begin
			sampleTick[s] = 1'b0;
			needThree[s]  = 1'b0;
			if (modeSlow) begin
				// every source on the slow tick
				sampleTick[s] = slowTick;
			end else if (modeFast) begin
				if (s == 0 || s == 5) begin
					// fixed sources sample each cycle
					sampleTick[s] = 1'b1;
				end else begin
					needThree[s] = 1'b1;
					case (ctrl_q[s].interval)
						2'h0: sampleTick[s] =
							(fastCnt_q & eic_pkg::MASK_DIV1) == 4'h0;
						2'h1: sampleTick[s] =
							(fastCnt_q & eic_pkg::MASK_DIV4) == 4'h0;
						2'h2: sampleTick[s] =
							(fastCnt_q & eic_pkg::MASK_DIV8) == 4'h0;
						2'h3: sampleTick[s] =
							(fastCnt_q & eic_pkg::MASK_DIV16) == 4'h0;
						default: sampleTick[s] = 1'b0;
					endcase
				end
			end
		end
	end

	// trigger selects; fixed sources use the falling edge
	always_comb begin
		trigSel[0] = eic_pkg::TRIG_FALL;
		trigSel[5] = eic_pkg::TRIG_FALL;
		for (int s = 1; s <= 4; s++) begin
			trigSel[s] = ctrl_q[s].trig;
		end
	end

	// ----------------------------------------
	// filter and trigger per source
	// ----------------------------------------

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : gSrc
			// noise canceller of this pin
			eic_noise_filter uFilt (
				.clk        (clk),
				.reset      (reset),
				.clockOn    (gate_q),
				.sampleTick (sampleTick[g]),
				.needThree  (needThree[g]),
				.pinIn      (extIrqLine[g]),
				.level      (filtLevel[g])
			);

			// request generation of this pin
			eic_trigger_detect #(
				.ALLOW_HIGH (g == 4)
			) uTrig (
				.clk        (clk),
				.reset      (reset),
				.clockOn    (gate_q),
				.allowReq   (modeRun),
				.trig       (trigSel[g]),
				.level      (filtLevel[g]),
				.request    (irqRequest[g]),
				.passLevel  (passLevel[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// gating toward the cpu
	// ----------------------------------------

	// accepted only with master and source flag set
	assign irqAccepted = irqRequest & sourceEnableFlag &
		{6{masterIntEnableFlag}};

endmodule

// ---- src/eic_pkg.sv ----
// Purpose: constants and types of the external interrupt conditioner
// Assumes: clk is the gear clock; registers are word aligned on APB
// Notes:   printed offsets are register indices, byte address = 4*index

package eic_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NUM_SRC = 6;
	localparam int ADDR_W  = 16;

	// ----------------------------------------
	// register indices and byte addresses
	// ----------------------------------------
	localparam logic [13:0] CTRL1_IDX = 14'h0fd8;
	localparam logic [13:0] CTRL2_IDX = 14'h0fd9;
	localparam logic [13:0] CTRL3_IDX = 14'h0fda;
	localparam logic [13:0] CTRL4_IDX = 14'h0fdb;
	localparam logic [13:0] GATE_IDX  = 14'h0fd0;
	localparam logic [15:0] CTRL1_ADDR = {CTRL1_IDX, 2'h0};
	localparam logic [15:0] CTRL2_ADDR = {CTRL2_IDX, 2'h0};
	localparam logic [15:0] CTRL3_ADDR = {CTRL3_IDX, 2'h0};
	localparam logic [15:0] CTRL4_ADDR = {CTRL4_IDX, 2'h0};
	localparam logic [15:0] GATE_ADDR  = {GATE_IDX, 2'h0};

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int INTERVAL_LSB = 0;
	localparam int TRIG_LSB     = 2;
	localparam int LEVEL_BIT    = 4;
	localparam int GATE_BIT     = 0;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic       GATE_RESET = 1'h0;

	// ----------------------------------------
	// trigger select codes
	// ----------------------------------------
	localparam logic [1:0] TRIG_RISE = 2'h0;
	localparam logic [1:0] TRIG_FALL = 2'h1;
	localparam logic [1:0] TRIG_BOTH = 2'h2;
	localparam logic [1:0] TRIG_HIGH = 2'h3;

	// ----------------------------------------
	// timing: sample interval masks, slow divider
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [3:0] MASK_DIV1  = 4'h0;
	localparam logic [3:0] MASK_DIV4  = 4'h3;
	localparam logic [3:0] MASK_DIV8  = 4'h7;
	localparam logic [3:0] MASK_DIV16 = 4'hf;
	localparam logic [1:0] SLOW_DIV_LAST = 2'h3;

	// operating mode, one-hot
	typedef enum logic [2:0] {
		MODE_FAST = 3'b001,
		MODE_SLOW = 3'b010,
		MODE_DEEP = 3'b100
	} eic_mode_t;

	// writable fields of a control register
	typedef struct packed {
		logic [1:0] trig;
		logic [1:0] interval;
	} eic_ctrl_t;

endpackage

// ---- src/eic_noise_filter.sv ----
// Purpose: sampling noise canceller for one interrupt pin
// Assumes: sampleTick marks each sampling instant
// Notes:   level holds while no tick arrives
`timescale 1ns/1ps
module eic_noise_filter (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic clockOn,
	input  wire logic sampleTick,
	input  wire logic needThree,
	input  wire logic pinIn,
	output logic      level
);
	logic [2:0] sample_q;   // newest sample in bit 0
	logic       level_q;    // accepted level
	logic [2:0] sample_d;   // history with new sample
	logic       agreeTwo;   // last two samples equal
	logic       agreeThree; // last three samples equal

	// candidate history and agreement
	always_comb begin
		sample_d   = {sample_q[1:0], pinIn};
		agreeTwo   = sample_d[0] == sample_d[1];
		agreeThree = agreeTwo && (sample_d[1] == sample_d[2]);
	end

	// sampling; stopped clock clears the history
	always_ff @(posedge clk) begin
		if (reset || !clockOn) begin
			sample_q <= 3'h0;
			level_q  <= 1'h0;
		end else if (sampleTick) begin
			sample_q <= sample_d;
			if (needThree ? agreeThree : agreeTwo) begin
				level_q <= sample_d[0];
			end
		end
	end

	assign level = level_q;
endmodule

// ---- src/eic_trigger_detect.sv ----
// Purpose: request generation from a filtered level
// Assumes: level comes from a noise canceller
// Notes:   high-level code only honoured when allowHigh is set
`timescale 1ns/1ps
module eic_trigger_detect #(
	parameter bit ALLOW_HIGH = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clockOn,
	input  wire logic       allowReq,
	input  wire logic [1:0] trig,
	input  wire logic       level,
	output logic            request,
	output logic            passLevel
);
	logic prev_q;  // level one cycle ago
	logic req_q;   // registered request
	logic pass_q;  // level seen at last request
	logic hit;     // trigger condition met

	// condition decode
	always_comb begin
		case (trig)
			eic_pkg::TRIG_RISE: hit = level && !prev_q;
			eic_pkg::TRIG_FALL: hit = !level && prev_q;
			eic_pkg::TRIG_BOTH: hit = level ^ prev_q;
			eic_pkg::TRIG_HIGH: hit = ALLOW_HIGH && level;
			default:            hit = 1'b0;
		endcase
	end

	// edge memory, request and pass level
	always_ff @(posedge clk) begin
		if (reset) begin
			prev_q <= 1'h0;
			req_q  <= 1'h0;
			pass_q <= 1'h0;
		end else if (!clockOn) begin
			prev_q <= 1'h0;
			req_q  <= 1'h0;
		end else begin
			prev_q <= level;
			req_q  <= hit && allowReq;
			if (hit && allowReq) begin
				pass_q <= level;
			end
		end
	end

	assign request   = req_q;
	assign passLevel = pass_q;
endmodule

// ---- tb/eic_sva.sv ----
// Purpose: port checker for the interrupt conditioner
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to eic_top below the module
`timescale 1ns/1ps
module eic_sva (
	input wire logic               clk,
	input wire logic               reset,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [15:0]        paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic [5:0]         extIrqLine,
	input wire logic               lowFreqClock,
	input wire eic_pkg::eic_mode_t opMode,
	input wire logic               masterIntEnableFlag,
	input wire logic [5:0]         sourceEnableFlag,
	input wire logic [5:0]         irqRequest,
	input wire logic [5:0]         irqAccepted,
	input wire logic               extIntClockGate
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_accept_gating: assert property (
		irqAccepted == (irqRequest & sourceEnableFlag
			& {6{masterIntEnableFlag}}))
		else $error("accepted mask mismatch");
	a_gate_reset: assert property (
		disable iff (1'b0) reset |=> !extIntClockGate && irqRequest == 6'h00)
		else $error("gate or request not cleared by reset");
	a_gate_quiet: assert property (
		!extIntClockGate && $past(extIntClockGate) == 1'b0
			|-> irqRequest == 6'h00)
		else $error("request while clock gated");
	a_deep_quiet: assert property (
		opMode == eic_pkg::MODE_DEEP && $past(opMode, 2) == eic_pkg::MODE_DEEP
			&& $past(opMode) == eic_pkg::MODE_DEEP |-> irqRequest == 6'h00)
		else $error("request in deep mode");
	a_pulse_edge: assert property (
		(irqRequest & 6'h2f) != 6'h00
			|=> (irqRequest & $past(irqRequest) & 6'h2f) == 6'h00)
		else $error("edge request longer than one cycle");
	a_ctrl_upper: assert property (
		psel && penable && !pwrite && paddr == eic_pkg::CTRL4_ADDR
			|-> prdata[31:5] == 27'h0)
		else $error("upper control bits not zero");
	a_gate_write: assert property (
		psel && penable && pwrite && paddr == eic_pkg::GATE_ADDR
			|=> extIntClockGate == $past(pwdata[0]))
		else $error("gate bit not written");
	// read data is loaded at the setup edge, so it must still stand one
	// edge after the access edge, and ready must be high in access
	a_read_stable: assert property (
		psel && penable |-> pready ##1 $stable(prdata))
		else $error("read data moved in access phase");
endmodule

bind eic_top eic_sva sva (.clk, .reset, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .extIrqLine, .lowFreqClock,
	.opMode, .masterIntEnableFlag, .sourceEnableFlag, .irqRequest,
	.irqAccepted, .extIntClockGate);

// ---- tb/eic_pin_source.sv ----
// Purpose: outside signal sources on the six interrupt pins
// Assumes: pins idle high; changes land just after a clock edge
// Notes:   pulse widths are whole gear clock cycles
`timescale 1ns/1ps
module eic_pin_source (
	input  wire logic       clk,
	output logic      [5:0] line
);
	// pins start at their idle level
	initial line = 6'h3f;

	// move one pin to a level after the next edge
	task automatic set(input int src, input logic lvl);
		@(posedge clk);
		line[src] <= lvl;
	endtask

	// pulse of width cycles, then back to the opposite level
	task automatic drive(input int src, input logic lvl, input int w);
		set(src, lvl);
		repeat (w) @(posedge clk);
		line[src] <= !lvl;
	endtask
endmodule

// ---- tb/eic_tb_top.sv ----
// Purpose: self-checking bench for the interrupt conditioner
// Assumes: APB master with bounded waits; pins from eic_pin_source
// Notes:   slow clock period is eight gear cycles
`timescale 1ns/1ps
module eic_tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic               clk, reset, psel, penable, pwrite, pready, pslverr;
	logic               lowFreqClock, masterIntEnableFlag, extIntClockGate;
	logic [15:0]        paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic [5:0]         extIrqLine, sourceEnableFlag, irqRequest, irqAccepted;
	logic [2:0]         lfCnt_q;
	logic               err;
	eic_pkg::eic_mode_t opMode;
	int                 fails, checks, n;

	eic_top dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .extIrqLine, .lowFreqClock, .opMode,
		.masterIntEnableFlag, .sourceEnableFlag, .irqRequest, .irqAccepted,
		.extIntClockGate);
	eic_pin_source pins (.clk, .line(extIrqLine));

	// gear clock and slow clock level
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		lfCnt_q <= lfCnt_q + 3'h1;
		lowFreqClock <= lfCnt_q[2];
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic conclude;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one APB transfer, read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [15:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			fails++;
			conclude();
		end
	endtask

	// control write with the source masked meanwhile
	task automatic wr4(input logic [7:0] v);
		sourceEnableFlag[4] <= 1'b0;
		apb(1'b1, eic_pkg::CTRL4_ADDR, {24'h0, v});
		repeat (40) @(posedge clk);
		sourceEnableFlag[4] <= 1'b1;
	endtask

	// pulse a pin and count accepted requests in a window; the count
	// looks mid-cycle, where the registered request has settled
	task automatic pc(input int src, input logic lvl, input int w,
		input int win);
		n = 0;
		fork
			pins.drive(src, lvl, w);
			repeat (win) begin
				@(negedge clk);
				if (irqAccepted[src] === 1'b1)
					n++;
			end
		join
	endtask

	// mode change with all sources masked, then a settle wait
	task automatic mode(input eic_pkg::eic_mode_t m);
		sourceEnableFlag <= 6'h00;
		opMode <= m;
		repeat (100) @(posedge clk);
		sourceEnableFlag <= 6'h3f;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk = 0;
		reset = 1;
		{psel, penable, pwrite, paddr, pwdata, lfCnt_q} = '0;
		lowFreqClock = 0;
		masterIntEnableFlag = 1;
		sourceEnableFlag = 6'h00;
		opMode = eic_pkg::MODE_FAST;
		repeat (10) @(posedge clk);
		reset <= 0;
		apb(1'b0, eic_pkg::GATE_ADDR, 0);
		chk("gate", 32'h0, rd);
		apb(1'b1, eic_pkg::CTRL4_ADDR, 32'hff);
		apb(1'b0, eic_pkg::CTRL4_ADDR, 0);
		chk("ctrl4 gated", 32'h0, rd);
		apb(1'b0, 16'h0ffc, 0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, eic_pkg::GATE_ADDR, 32'h1);
		pins.set(4, 1'b0);
		repeat (40) @(posedge clk);
		sourceEnableFlag <= 6'h3f;
		wr4(8'hff);
		apb(1'b0, eic_pkg::CTRL4_ADDR, 0);
		chk("ctrl4", 32'h0f, rd);
		// fixed falling-edge sources
		for (int s = 0; s < 6; s += 5) begin
			pc(s, 1'b0, 1, 60);
			chk("glitch", 0, 32'(n));
			pc(s, 1'b0, 4, 60);
			chk("pulse", 1, 32'(n));
		end
		masterIntEnableFlag <= 1'b0;
		pc(0, 1'b0, 4, 60);
		chk("master off", 0, 32'(n));
		masterIntEnableFlag <= 1'b1;
		// every interval at both edges, narrow and wide
		for (int i = 0; i < 4; i++) begin
			wr4({4'h0, eic_pkg::TRIG_BOTH, 2'(i)});
			pc(4, 1'b1, (i == 0) ? 1 : 2 * (2 << i) - 1, 100);
			chk("narrow", 0, 32'(n));
			pc(4, 1'b1, (i == 0) ? 5 : 3 * (2 << i) + 2, 150);
			chk("wide", 2, 32'(n));
		end
		wr4({4'h0, eic_pkg::TRIG_RISE, 2'h0});
		pc(4, 1'b1, 6, 60);
		chk("rise", 1, 32'(n));
		apb(1'b0, eic_pkg::CTRL4_ADDR, 0);
		chk("level high", 32'h10, rd);
		wr4({4'h0, eic_pkg::TRIG_FALL, 2'h0});
		pc(4, 1'b1, 6, 60);
		chk("fall", 1, 32'(n));
		apb(1'b0, eic_pkg::CTRL4_ADDR, 0);
		chk("level low", 32'h04, rd);
		wr4({4'h0, eic_pkg::TRIG_HIGH, 2'h0});
		pc(4, 1'b1, 40, 40);
		chk("held", 1, {31'h0, n >= 30});
		wr4({4'h0, eic_pkg::TRIG_RISE, 2'h3});
		// slow mode sampling at slow clock over four, then deep and fast
		mode(eic_pkg::MODE_SLOW);
		pc(0, 1'b0, 24, 200);
		chk("slow short", 0, 32'(n));
		pc(0, 1'b0, 64, 200);
		chk("slow long", 1, 32'(n));
		mode(eic_pkg::MODE_DEEP);
		pc(0, 1'b0, 8, 60);
		chk("deep", 0, 32'(n));
		mode(eic_pkg::MODE_FAST);
		pc(0, 1'b0, 4, 60);
		chk("resumed", 1, 32'(n));
		// gate off with sources masked around the change
		sourceEnableFlag <= 6'h00;
		apb(1'b1, eic_pkg::GATE_ADDR, 32'h0);
		repeat (20) @(posedge clk);
		sourceEnableFlag <= 6'h3f;
		pc(0, 1'b0, 8, 60);
		chk("gate off", 0, 32'(n));
		conclude();
	end
endmodule
